//--- rtl/pcu_pkg.sv
// Shared constants and types for the projector setting command unit
package pcu_pkg;

  // ****************************************
  // Command codes and modifiers
  // ****************************************
  typedef enum logic [3:0] {
    fade_time_cmd           = 4'h0,
    lens_focus_cmd          = 4'h1,
    input_filter_cmd        = 4'h2,
    floating_input_cmd      = 4'h3,
    frame_timing_mode_cmd   = 4'h4,
    film_threshold_cmd      = 4'h5,
    output_delay_cmd        = 4'h6,
    image_hold_cmd          = 4'h7,
    fan_watch_cmd           = 4'h8,
    error_report_enable_cmd = 4'h9
  } pcu_cmd_t;

  typedef enum logic [1:0] {
    mod_none   = 2'h0,
    mod_store  = 2'h1,
    mod_limits = 2'h2,
    mod_key    = 2'h3
  } pcu_mod_t;

  typedef enum logic [1:0] {
    motion_stop = 2'h0,
    motion_fwd  = 2'h1,
    motion_rev  = 2'h2
  } pcu_motion_t;

  // ****************************************
  // Ranges
  // ****************************************
  localparam int FADE_MAX      = 150;
  localparam int FILTER_MAX    = 4;
  localparam int FRAME_MODE_MAX = 2;
  localparam int FILM_MAX      = 255;
  localparam int ERE_MAX       = 4;
  localparam int STORE_POS_MAX = 9999;
  localparam int FOCUS_MIN_DEF = -1200;
  localparam int FOCUS_MAX_DEF = 1200;

  // Lens key codes
  localparam logic signed [15:0] KEY_STOP  = 16'sh0000;
  localparam logic signed [15:0] KEY_DIR   = 16'sh0002;
  localparam logic signed [15:0] KEY_START = 16'sh0003;

  // Report target settings
  localparam logic [2:0] ERE_OFF    = 3'h0;
  localparam logic [2:0] ERE_OSD    = 3'h1;
  localparam logic [2:0] ERE_SERIAL = 3'h2;
  localparam logic [2:0] ERE_BOTH   = 3'h3;
  localparam logic [2:0] ERE_NOSYNC = 3'h4;

  // ****************************************
  // Status codes and states
  // ****************************************
  localparam logic [7:0] ST_POWER  = 8'h01;
  localparam logic [7:0] ST_ADDR   = 8'h02;
  localparam logic [7:0] ST_SELECT = 8'h03;
  localparam logic [7:0] ST_BAUD   = 8'h04;
  localparam logic [7:0] ST_STDBY  = 8'h05;
  localparam logic [7:0] ST_SIGNAL = 8'h06;
  localparam logic [7:0] ST_OSD    = 8'h07;
  localparam logic [7:0] ST_SHUT   = 8'h09;
  localparam logic [7:0] ST_INPUT  = 8'h0a;
  localparam logic [7:0] ST_MUTE   = 8'h0b;
  localparam logic [7:0] ST_PIP    = 8'h0c;
  localparam logic [7:0] ST_MISC   = 8'hff;
  localparam logic [15:0] PWR_OFF  = 16'h0000;
  localparam logic [15:0] PWR_ON   = 16'h0001;
  localparam logic [15:0] PWR_BOOT = 16'h0002;
  localparam logic [15:0] PWR_COOL = 16'h000a;
  localparam logic [15:0] PWR_WARM = 16'h000b;
  localparam logic [15:0] SIG_MAX  = 16'h0002;
  localparam logic [15:0] SEL_MAX  = 16'h0003;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int FADE_STEP_US  = 10000;
  localparam int FADE_TICK_DEF = FADE_STEP_US * 1000 / CLK_PERIOD_NS;
  localparam longint FAN_DELAY_S = 180;
  localparam longint FAN_DELAY_DEF = FAN_DELAY_S * 64'd1000000000 / CLK_PERIOD_NS;

endpackage

//--- rtl/pcu_setting.sv
// Range-checked setting register with optional hardware clear
`timescale 1ns/1ps
`default_nettype none

module pcu_setting #(
  parameter int W   = 8,
  parameter int MIN = 0,
  parameter int MAX = 255,
  parameter int RST = 0
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Write side
  input  wire logic               wr,
  input  wire logic signed [15:0] din,
  input  wire logic               clr,
  // Stored value
  output logic         [W-1:0]    q
);

  logic in_range;

  assign in_range = ($signed(din) >= MIN) && ($signed(din) <= MAX);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= W'(RST);
    end else if (wr && in_range) begin
      q <= din[W-1:0];
    end else if (clr) begin
      q <= W'(RST);
    end
  end

  a_range_keep: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && !in_range && !clr) |=> $stable(q))
    else $error("Out of range write changed setting");

endmodule
`default_nettype wire

//--- rtl/pcu_fan_timer.sv
// Fan failure shutdown delay
`timescale 1ns/1ps
`default_nettype none

module pcu_fan_timer
  import pcu_pkg::*;
#(
  parameter longint DELAY = FAN_DELAY_DEF,
  parameter int     CW    = 34
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Control
  input  wire logic en,
  input  wire logic fan_fail,
  // Result
  output logic      shutdown
);

  logic [CW-1:0] cnt;
  logic          done;

  assign done = (cnt == CW'(DELAY - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt      <= '0;
      shutdown <= 1'b0;
    end else if (!en) begin
      cnt      <= '0;
      shutdown <= 1'b0;
    end else if (fan_fail && !shutdown) begin
      cnt      <= done ? cnt : cnt + CW'(1);
      shutdown <= done;
    end else if (!fan_fail) begin
      cnt <= '0;
    end
  end

  a_fan_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !en |=> !shutdown)
    else $error("Shutdown with fan watch off");

endmodule
`default_nettype wire

//--- rtl/pcu_top.sv
// Projector setting command unit: settings, lens focus and status broadcast
// Operation
// - Source switch fades over programmed hundredths of second, 0..150, 0 disables.
// - Store modifier saves 0..9999 per channel; moves lens if channel active.
// - Limits modifier query replies with focus minimum and maximum.
// - Plain position moves active channel lens and records it for that channel.
// - Focus range defaults -1200..1200, replaced after lens calibration.
// - Direction key starts motion until stop key or end stop.
// - Without stored positions, no focus value kept; key emulation only.
// - Input filter codes 0 off, 1 HDTV, 2 SDTV, 3 EDTV, 4 graphics.
// - Floating inputs enabled by 1, disabled by 0, readable by query.
// - Frame timing 0 rate matched, 1 locked, 2 free run 60Hz.
// - Film threshold accepts 0..255.
// - Frame delay shifts output later, fraction to several frames.
// - Freeze holds on 1, releases on 0; channel switch clears it unless a write of 1 arrives in the same cycle.
// - With fan watch on, shut down 3 minutes after fan failure.
// - Status change broadcasts address, code, state, two details, text.
// - Broadcasts suppressed while error reporting is off.
// - Status codes 001..007, 009..012 and 255.
// - Power states 0 off, 1 on, 2 boot, 10 cool, 11 warm.
// - Signal state 0 good, 1 missing, 2 bad sync, plus frequencies.
// - Selection state 0..3 combining serial and user activity.
// - Error reporting 0 off, 1 screen, 2 serial, 3 both, 4 no sync.
`timescale 1ns/1ps
`default_nettype none

module pcu_top
  import pcu_pkg::*;
#(
  parameter int     N_CHAN           = 16,
  parameter int     CH_W             = 4,
  parameter int     DLY_W            = 8,
  parameter int     DLY_MAX          = 255,
  parameter int     FADE_TICK_CYCLES = FADE_TICK_DEF,
  parameter longint FAN_DELAY_CYCLES = FAN_DELAY_DEF
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Command in
  input  wire logic               cmd_valid,
  input  wire logic               cmd_query,
  input  wire logic         [3:0] cmd_code,
  input  wire logic         [1:0] cmd_mod,
  input  wire logic signed [15:0] cmd_p1,
  input  wire logic signed [15:0] cmd_p2,
  // Query reply
  output logic                    reply_valid,
  output logic              [3:0] reply_code,
  output logic       signed [15:0] reply_p1,
  output logic       signed [15:0] reply_p2,
  // Projector state in
  input  wire logic               lens_store_present,
  input  wire logic    [CH_W-1:0] active_chan,
  input  wire logic               chan_switch,
  input  wire logic               cal_valid,
  input  wire logic signed [15:0] cal_min,
  input  wire logic signed [15:0] cal_max,
  input  wire logic               lens_end_stop,
  input  wire logic               fan_fail,
  input  wire logic        [15:0] unit_address,
  // Settings out
  output logic              [7:0] fade_time,
  output logic                    fade_active,
  output logic              [2:0] input_filter,
  output logic                    floating_inputs,
  output logic              [1:0] frame_mode,
  output logic              [7:0] film_threshold,
  output logic        [DLY_W-1:0] output_delay,
  output logic                    image_hold,
  output logic                    fan_watch_en,
  output logic                    fan_shutdown,
  output logic              [2:0] error_report_enable,
  output logic                    err_osd_en,
  output logic                    err_serial_en,
  output logic                    err_sync_en,
  // Lens drive
  output logic                    lens_move,
  output logic       signed [15:0] lens_target,
  output logic              [1:0] lens_motion,
  // Status change in
  input  wire logic               stat_valid,
  input  wire logic         [7:0] stat_code,
  input  wire logic        [15:0] stat_state,
  input  wire logic        [15:0] stat_p2,
  input  wire logic        [15:0] stat_p3,
  input  wire logic         [1:0] stat_nextra,
  // Status broadcast out
  output logic                    bcast_valid,
  output logic             [15:0] bcast_addr,
  output logic              [7:0] bcast_code,
  output logic             [15:0] bcast_state,
  output logic             [15:0] bcast_p2,
  output logic             [15:0] bcast_p3,
  output logic              [1:0] bcast_nextra
);

  // ****************************************
  // Command decode
  // ****************************************
  logic wr_base;
  logic is_focus;
  logic focus_cmd;
  logic qry;

  assign qry       = cmd_valid && cmd_query;
  assign wr_base   = cmd_valid && !cmd_query && (cmd_mod == mod_none);
  assign is_focus  = (cmd_code == lens_focus_cmd);
  assign focus_cmd = cmd_valid && !cmd_query && is_focus;

  // ****************************************
  // Plain settings
  // ****************************************
  pcu_setting #(.W(8), .MIN(0), .MAX(FADE_MAX), .RST(0)) u_fade (
    .clk(clk), .rst_b(rst_b), .din(cmd_p1), .clr(1'b0), .q(fade_time),
    .wr(wr_base && cmd_code == fade_time_cmd));
  pcu_setting #(.W(3), .MIN(0), .MAX(FILTER_MAX), .RST(0)) u_filt (
    .clk(clk), .rst_b(rst_b), .din(cmd_p1), .clr(1'b0), .q(input_filter),
    .wr(wr_base && cmd_code == input_filter_cmd));
  pcu_setting #(.W(1), .MIN(0), .MAX(1), .RST(0)) u_float (
    .clk(clk), .rst_b(rst_b), .din(cmd_p1), .clr(1'b0), .q(floating_inputs),
    .wr(wr_base && cmd_code == floating_input_cmd));
  pcu_setting #(.W(2), .MIN(0), .MAX(FRAME_MODE_MAX), .RST(0)) u_frm (
    .clk(clk), .rst_b(rst_b), .din(cmd_p1), .clr(1'b0), .q(frame_mode),
    .wr(wr_base && cmd_code == frame_timing_mode_cmd));
  pcu_setting #(.W(8), .MIN(0), .MAX(FILM_MAX), .RST(0)) u_film (
    .clk(clk), .rst_b(rst_b), .din(cmd_p1), .clr(1'b0), .q(film_threshold),
    .wr(wr_base && cmd_code == film_threshold_cmd));
  pcu_setting #(.W(DLY_W), .MIN(0), .MAX(DLY_MAX), .RST(0)) u_dly (
    .clk(clk), .rst_b(rst_b), .din(cmd_p1), .clr(1'b0), .q(output_delay),
    .wr(wr_base && cmd_code == output_delay_cmd));
  pcu_setting #(.W(1), .MIN(0), .MAX(1), .RST(0)) u_hold (
    .clk(clk), .rst_b(rst_b), .din(cmd_p1), .clr(chan_switch), .q(image_hold),
    .wr(wr_base && cmd_code == image_hold_cmd));
  pcu_setting #(.W(1), .MIN(0), .MAX(1), .RST(0)) u_fan (
    .clk(clk), .rst_b(rst_b), .din(cmd_p1), .clr(1'b0), .q(fan_watch_en),
    .wr(wr_base && cmd_code == fan_watch_cmd));
  pcu_setting #(.W(3), .MIN(0), .MAX(ERE_MAX), .RST(0)) u_ere (
    .clk(clk), .rst_b(rst_b), .din(cmd_p1), .clr(1'b0), .q(error_report_enable),
    .wr(wr_base && cmd_code == error_report_enable_cmd));

  pcu_fan_timer #(.DELAY(FAN_DELAY_CYCLES)) u_fan_tmr (
    .clk      (clk),
    .rst_b    (rst_b),
    .en       (fan_watch_en),
    .fan_fail (fan_fail),
    .shutdown (fan_shutdown)
  );

  // ****************************************
  // Report targets
  // ****************************************
  logic next_osd;
  logic next_ser;
  logic next_sync;

  assign next_osd  = (error_report_enable == ERE_OSD) ||
                     (error_report_enable == ERE_BOTH) ||
                     (error_report_enable == ERE_NOSYNC);
  assign next_ser  = (error_report_enable == ERE_SERIAL) ||
                     (error_report_enable == ERE_BOTH) ||
                     (error_report_enable == ERE_NOSYNC);
  assign next_sync = next_osd && (error_report_enable != ERE_NOSYNC);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_osd_en    <= 1'b0;
      err_serial_en <= 1'b0;
      err_sync_en   <= 1'b0;
    end else begin
      err_osd_en    <= next_osd;
      err_serial_en <= next_ser;
      err_sync_en   <= next_sync || (error_report_enable == ERE_SERIAL);
    end
  end

  // ****************************************
  // Fade engine
  // ****************************************
  logic [31:0] fade_tick;
  logic  [7:0] fade_left;
  logic        tick_done;

  assign tick_done = (fade_tick == 32'(FADE_TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fade_active <= 1'b0;
      fade_tick   <= '0;
      fade_left   <= '0;
    end else if (chan_switch) begin
      fade_active <= (fade_time != 8'h00);
      fade_tick   <= '0;
      fade_left   <= fade_time;
    end else if (fade_active) begin
      fade_tick <= tick_done ? '0 : fade_tick + 32'd1;
      if (tick_done) begin
        fade_left   <= fade_left - 8'h01;
        fade_active <= (fade_left != 8'h01);
      end
    end
  end

  // ****************************************
  // Lens focus
  // ****************************************
  logic signed [15:0] focus_min;
  logic signed [15:0] focus_max;
  logic signed [15:0] lens_pos [N_CHAN];
  logic  [N_CHAN-1:0] pos_valid;
  logic    [CH_W-1:0] chan;
  logic               chan_ok;
  logic               wr_store;
  logic               wr_direct;
  logic               key_cmd;
  logic         [1:0] next_motion;

  assign chan      = cmd_p1[CH_W-1:0];
  assign chan_ok   = (cmd_p1 >= 0) && (cmd_p1 < N_CHAN);
  assign wr_store  = focus_cmd && (cmd_mod == mod_store) && lens_store_present &&
                     chan_ok && (cmd_p2 >= 0) && (cmd_p2 <= STORE_POS_MAX);
  assign wr_direct = focus_cmd && (cmd_mod == mod_none) && lens_store_present &&
                     (cmd_p1 >= focus_min) && (cmd_p1 <= focus_max);
  assign key_cmd   = focus_cmd && (cmd_mod == mod_key);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      focus_min <= 16'(FOCUS_MIN_DEF);
      focus_max <= 16'(FOCUS_MAX_DEF);
    end else if (cal_valid && (cal_min <= cal_max)) begin
      focus_min <= cal_min;
      focus_max <= cal_max;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_store) begin
      lens_pos[chan] <= cmd_p2;
    end else if (wr_direct) begin
      lens_pos[active_chan] <= cmd_p1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_valid   <= '0;
      lens_move   <= 1'b0;
      lens_target <= '0;
    end else begin
      lens_move <= (wr_store && chan == active_chan) || wr_direct;
      if (wr_store) begin
        pos_valid[chan] <= 1'b1;
      end else if (wr_direct) begin
        pos_valid[active_chan] <= 1'b1;
      end
      if (wr_direct) begin
        lens_target <= cmd_p1;
      end else if (wr_store && chan == active_chan) begin
        lens_target <= cmd_p2;
      end
    end
  end

  // Key emulation motion
  always_comb begin
    next_motion = lens_motion;
    if (lens_end_stop) begin
      next_motion = motion_stop;
    end
    if (key_cmd) begin
      case (cmd_p1)
        KEY_STOP:  next_motion = motion_stop;
        KEY_START: next_motion = motion_fwd;
        KEY_DIR:   next_motion = (cmd_p2 == 16'sh0000) ? motion_fwd : motion_rev;
        default:   next_motion = lens_motion;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lens_motion <= motion_stop;
    end else begin
      lens_motion <= next_motion;
    end
  end

  // ****************************************
  // Query reply
  // ****************************************
  logic signed [15:0] q_p1;
  logic signed [15:0] q_p2;
  logic signed [15:0] q_set;

  assign q_set =
    (cmd_code == fade_time_cmd)          ? 16'(fade_time) :
    (cmd_code == input_filter_cmd)       ? 16'(input_filter) :
    (cmd_code == floating_input_cmd)     ? 16'(floating_inputs) :
    (cmd_code == frame_timing_mode_cmd)  ? 16'(frame_mode) :
    (cmd_code == film_threshold_cmd)     ? 16'(film_threshold) :
    (cmd_code == output_delay_cmd)       ? 16'(output_delay) :
    (cmd_code == image_hold_cmd)         ? 16'(image_hold) :
    (cmd_code == fan_watch_cmd)          ? 16'(fan_watch_en) :
    (cmd_code == error_report_enable_cmd) ? 16'(error_report_enable) :
                                           lens_target;
  assign q_p1 = (is_focus && cmd_mod == mod_limits) ? focus_min : q_set;
  assign q_p2 =
    (is_focus && cmd_mod == mod_limits) ? focus_max :
    (is_focus && cmd_mod == mod_store && chan_ok && pos_valid[chan]) ? lens_pos[chan] :
    16'sh0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reply_valid <= 1'b0;
      reply_code  <= '0;
      reply_p1    <= '0;
      reply_p2    <= '0;
    end else begin
      reply_valid <= qry;
      if (qry) begin
        reply_code <= cmd_code;
        reply_p1   <= q_p1;
        reply_p2   <= q_p2;
      end
    end
  end

  // ****************************************
  // Status broadcast
  // ****************************************
  logic code_ok;
  logic state_ok;
  logic bc_go;

  assign code_ok = (stat_code >= ST_POWER && stat_code <= ST_OSD) ||
                   (stat_code >= ST_SHUT && stat_code <= ST_PIP) ||
                   (stat_code == ST_MISC);
  assign state_ok =
    (stat_code == ST_POWER)  ? (stat_state == PWR_OFF || stat_state == PWR_ON ||
                                stat_state == PWR_BOOT || stat_state == PWR_COOL ||
                                stat_state == PWR_WARM) :
    (stat_code == ST_SIGNAL) ? (stat_state <= SIG_MAX) :
    (stat_code == ST_SELECT) ? (stat_state <= SEL_MAX) :
    1'b1;
  assign bc_go = stat_valid && code_ok && state_ok &&
                 (error_report_enable != ERE_OFF);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bcast_valid  <= 1'b0;
      bcast_addr   <= '0;
      bcast_code   <= '0;
      bcast_state  <= '0;
      bcast_p2     <= '0;
      bcast_p3     <= '0;
      bcast_nextra <= '0;
    end else begin
      bcast_valid <= bc_go;
      if (bc_go) begin
        bcast_addr   <= unit_address;
        bcast_code   <= stat_code;
        bcast_state  <= stat_state;
        bcast_p2     <= stat_p2;
        bcast_p3     <= stat_p3;
        bcast_nextra <= stat_nextra;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_store_active;
    wr_store && chan == active_chan;
  endsequence
  sequence s_move_out(logic signed [15:0] pos);
    lens_move && lens_target == pos;
  endsequence

  a_store_move: assert property (s_store_active |=> s_move_out($past(cmd_p2)))
    else $error("Stored position did not move active lens");
  a_limits_reply: assert property ((qry && is_focus && cmd_mod == mod_limits) |=>
    reply_valid && reply_p1 == $past(focus_min) && reply_p2 == $past(focus_max))
    else $error("Limits reply wrong");
  a_nostore_still: assert property (!lens_store_present |=> !lens_move)
    else $error("Lens moved without stored positions");
  a_key_stop: assert property ((key_cmd && cmd_p1 == KEY_STOP) |=>
    lens_motion == motion_stop)
    else $error("Stop key did not stop lens");
  a_hold_clear: assert property ((chan_switch && !(wr_base && cmd_code == image_hold_cmd))
    |=> !image_hold)
    else $error("Freeze survived channel switch");
  a_bcast_gate: assert property ((error_report_enable == ERE_OFF) |=> !bcast_valid)
    else $error("Broadcast while reporting off");
  a_bcast_power: assert property ((bcast_valid && bcast_code == ST_POWER) |->
    (bcast_state <= PWR_BOOT || bcast_state == PWR_COOL || bcast_state == PWR_WARM))
    else $error("Bad power state broadcast");
  a_fade_start: assert property ((chan_switch && fade_time != 8'h00) |=>
    fade_active ##1 fade_active)
    else $error("Fade did not start");

endmodule
`default_nettype wire

//--- tb/pcu_ctrl_model.sv
// Remote controller model issuing one command per request
`timescale 1ns/1ps
`default_nettype none
module pcu_ctrl_model (
  // Clock, reset and request
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               req,
  input  wire logic               req_q,
  input  wire logic        [3:0]  req_code,
  input  wire logic        [1:0]  req_mod,
  input  wire logic signed [15:0] req_p1,
  input  wire logic signed [15:0] req_p2,
  // Command out
  output logic                    cmd_valid,
  output logic                    cmd_query,
  output logic             [3:0]  cmd_code,
  output logic             [1:0]  cmd_mod,
  output logic      signed [15:0] cmd_p1,
  output logic      signed [15:0] cmd_p2
);
  // Idle fields toggle so no stale value looks valid
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {cmd_valid, cmd_query, cmd_code, cmd_mod, cmd_p1, cmd_p2} <= '0;
    end else begin
      cmd_valid <= req;
      cmd_query <= req ? req_q : ~cmd_query;
      cmd_code <= req ? req_code : ~cmd_code;
      cmd_mod <= req ? req_mod : ~cmd_mod;
      cmd_p1 <= req ? req_p1 : ~cmd_p1;
      cmd_p2 <= req ? req_p2 : ~cmd_p2;
    end
  end
endmodule
`default_nettype wire

//--- tb/pcu_top_tb.sv
// Self-checking bench for the projector setting command unit
`timescale 1ns/1ps
`default_nettype none
module pcu_top_tb;
  import pcu_pkg::*;
  logic clk, rst_b, req, req_q, cmd_valid, cmd_query, reply_valid, lens_store_present;
  logic chan_switch, cal_valid, lens_end_stop, fan_fail, stat_valid, fade_active;
  logic floating_inputs, image_hold, fan_watch_en, fan_shutdown, err_osd_en, err_serial_en;
  logic err_sync_en, lens_move, bcast_valid, ok;
  logic [3:0] req_code, cmd_code, reply_code, active_chan;
  logic [1:0] req_mod, cmd_mod, frame_mode, lens_motion, stat_nextra, bcast_nextra;
  logic signed [15:0] req_p1, req_p2, cmd_p1, cmd_p2, reply_p1, reply_p2, cal_min, cal_max;
  logic signed [15:0] lens_target;
  logic [15:0] unit_address, stat_state, stat_p2, stat_p3, bcast_addr, bcast_state;
  logic [15:0] bcast_p2, bcast_p3;
  logic [7:0] fade_time, film_threshold, output_delay, stat_code, bcast_code;
  logic [2:0] input_filter, error_report_enable;
  int bad_count, n_checks, c, p, e, seed, cyc = 0;
  int mx[10] = '{150, 0, 4, 1, 2, 255, 255, 1, 1, 4};
  int exp_s[10] = '{default: 0};
  int sc[14] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 255, 13};

  pcu_ctrl_model pcu_ctrl_model_inst (.*);
  pcu_top #(.FADE_TICK_CYCLES(4), .FAN_DELAY_CYCLES(20)) pcu_top_inst (.*);

  function automatic logic [15:0] setting(input int k);
    case (k)
      0: return fade_time;
      2: return input_filter;
      3: return floating_inputs;
      4: return frame_mode;
      5: return film_threshold;
      6: return output_delay;
      7: return image_hold;
      8: return fan_watch_en;
      default: return error_report_enable;
    endcase
  endfunction

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (e !== s) begin
      bad_count++;
      $display("ERROR %s exp %0h got %0h", n, e, s);
    end
  endtask

  task automatic send(input logic q, input int k, input logic [1:0] m, input int a, b);
    @(posedge clk);
    req <= 1'b1;
    req_q <= q;
    req_code <= k[3:0];
    req_mod <= m;
    req_p1 <= a[15:0];
    req_p2 <= b[15:0];
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    seed = 32'h7649;
    {req, req_q, req_code, req_mod, req_p1, req_p2, cal_valid, cal_min, cal_max} = '0;
    {lens_store_present, chan_switch, lens_end_stop, fan_fail, stat_valid, active_chan} = '0;
    {stat_code, stat_state, stat_p2, stat_p3, stat_nextra} = '0;
    unit_address = 16'h1234;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 80; i++) begin
      c = {$random(seed)} % 10;
      c = (c == 1) ? 7 : c;
      p = (i % 4 == 0) ? mx[c] + (i % 8) / 4 : {$random(seed)} % (mx[c] + 3);
      send(1'b0, c, mod_none, p, 0);
      exp_s[c] = (p <= mx[c]) ? p : exp_s[c];
      chk("set", exp_s[c], setting(c));
      send(1'b1, c, mod_none, 0, 0);
      chk("query", exp_s[c], reply_p1);
      chk("reply", 16'({1'b1, c[3:0]}), 16'({reply_valid, reply_code}));
      e = {exp_s[9] inside {1, 3, 4}, exp_s[9] inside {2, 3, 4}, exp_s[9] inside {1, 2, 3}};
      chk("ere", 16'(e), {13'h0, err_osd_en, err_serial_en, err_sync_en});
    end
    lens_store_present <= 1'b1;
    active_chan <= 4'h3;
    send(1'b1, 1, mod_limits, 3, 0);
    chk("fmin", -16'sd1200, reply_p1);
    chk("fmax", 16'sd1200, reply_p2);
    send(1'b0, 1, mod_none, 1200, 0);
    chk("target", 16'sd1200, lens_target);
    send(1'b0, 1, mod_none, 1201, 0);
    chk("range", 16'h0, lens_move);
    send(1'b0, 1, mod_store, 5, 9999);
    chk("idle", 16'h0, lens_move);
    send(1'b1, 1, mod_store, 5, 0);
    chk("recall", 16'sd9999, reply_p2);
    send(1'b0, 1, mod_store, 3, 4000);
    chk("smove", 16'sd4000, lens_target);
    cal_min <= -16'sd500;
    cal_max <= 16'sd700;
    cal_valid <= 1'b1;
    send(1'b1, 1, mod_limits, 3, 0);
    cal_valid <= 1'b0;
    chk("cmin", -16'sd500, reply_p1);
    chk("cmax", 16'sd700, reply_p2);
    lens_store_present <= 1'b0;
    send(1'b0, 1, mod_none, 10, 0);
    chk("nostore", 16'h0, lens_move);
    send(1'b0, 1, mod_key, KEY_START, 0);
    chk("fwd", 16'h1, lens_motion);
    repeat (8) @(posedge clk);
    chk("run", 16'h1, lens_motion);
    send(1'b0, 1, mod_key, KEY_STOP, 0);
    chk("stop", 16'h0, lens_motion);
    send(1'b0, 1, mod_key, KEY_DIR, 1);
    chk("rev", 16'h2, lens_motion);
    lens_end_stop <= 1'b1;
    @(posedge clk);
    #1;
    chk("endstop", 16'h0, lens_motion);
    send(1'b0, 7, mod_none, 1, 0);
    send(1'b0, 0, mod_none, 2, 0);
    chan_switch <= 1'b1;
    @(posedge clk);
    chan_switch <= 1'b0;
    #1;
    chk("unfreeze", 16'h0, image_hold);
    repeat (7) @(posedge clk);
    #1;
    chk("fading", 16'h1, fade_active);
    @(posedge clk);
    #1;
    chk("faded", 16'h0, fade_active);
    send(1'b0, 8, mod_none, 1, 0);
    fan_fail <= 1'b1;
    repeat (15) @(posedge clk);
    fan_fail <= 1'b0;
    @(posedge clk);
    fan_fail <= 1'b1;
    repeat (19) @(posedge clk);
    #1;
    chk("early", 16'h0, fan_shutdown);
    @(posedge clk);
    #1;
    chk("shutdown", 16'h1, fan_shutdown);
    send(1'b0, 9, mod_none, 2, 0);
    for (int i = 0; i < 40; i++) begin
      if (i == 20) send(1'b0, 9, mod_none, 0, 0);
      c = sc[i % 14];
      p = {$random(seed)} % 12;
      @(posedge clk);
      stat_valid <= 1'b1;
      stat_code <= c[7:0];
      stat_state <= p[15:0];
      stat_p2 <= 16'($random(seed));
      stat_p3 <= 16'($random(seed));
      stat_nextra <= 2'(i);
      @(posedge clk);
      stat_valid <= 1'b0;
      #1;
      ok = i < 20 && !(c inside {8, 13}) && !(c == 1 && !(p inside {0, 1, 2, 10, 11}));
      ok = ok && !(c == 6 && p > 2) && !(c == 3 && p > 3);
      chk("bcast", {15'h0, ok}, bcast_valid);
      if (ok) chk("bcode", 16'(c), 16'(bcast_code));
      if (ok) chk("baddr", 16'h1234, bcast_addr);
      if (ok) chk("bstate", 16'(p), bcast_state);
      if (ok) chk("bp2", stat_p2, bcast_p2);
      if (ok) chk("bp3", stat_p3, bcast_p3);
      if (ok) chk("bnx", 16'(stat_nextra), 16'(bcast_nextra));
    end
    end_of_test();
  end
endmodule
`default_nettype wire
